/* File: verilog/status_led_regs.svh */
// Timing counts and defaults for the status LED block
`ifndef STATUS_LED_REGS_SVH
`define STATUS_LED_REGS_SVH

`define CLK_FREQ_HZ      100000000
`define SLOT_TIME_MS     1000
`define GAP_TIME_MS      3000
`define SLOT_CYCLES      ((`CLK_FREQ_HZ / 1000) * `SLOT_TIME_MS)
`define GAP_SLOTS        3
`define HOLD_LOW_DEFAULT 1'b0
`define DIO_WIDTH        8

`endif

/* File: verilog/status_led_pkg.sv */
// Types shared by the status LED block
package status_led_pkg;

  typedef enum logic [2:0] {
    show_off,
    show_on,
    show_attached,
    show_addressed,
    show_supply_fail,
    show_error
  } led_show_t;

  typedef enum logic [1:0] {
    seq_idle,
    seq_flash,
    seq_gap
  } seq_state_t;

endpackage

/* File: verilog/slot_timer.sv */
// Divider making the one-second slot enable pulse
`timescale 1ns/100ps
`default_nettype none
`include "status_led_regs.svh"
module slot_timer #(
  parameter int unsigned SLOT_CYCLES = `SLOT_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      slot_tick,
  output logic      half_tick
);

  logic [31:0] count;
  wire         at_end  = (count == 32'(SLOT_CYCLES - 1));
  wire         at_half = (count == 32'(SLOT_CYCLES / 2 - 1));

  always_ff @(posedge clk_sys) begin
    if (!rst_n || restart || at_end) begin
      count <= 32'h0;
    end else begin
      count <= count + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slot_tick <= 1'b0;
      half_tick <= 1'b0;
    end else begin
      slot_tick <= at_end && !restart;
      half_tick <= at_half && !restart;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/status_led.sv */
// Status LED patterns, overcurrent shutdown and suspend handling
// What this block does
// - LED steady on once configured.
// - LED dark when unpowered or low-power suspended.
// - One flash per cycle when attached.
// - Two flashes per cycle when addressed.
// - Three flashes after supply shutdown.
// - Four flashes in general fault state.
// - Each flash lights the first half of a one-second slot.
// - Three-second dark gap after last flash.
// - Overcurrent switches off most internal circuitry.
// - Overcurrent shows the supply-overload pattern.
// - Power loss aborts acquisition, drops results.
// - Suspend: low power or static, host-selected.
// - Default stays fully powered during suspend.
// - Static suspend freezes dio_out; the LED keeps its pattern.
// - Operate only while host powered; attach state only picks the LED pattern.
`timescale 1ns/100ps
`default_nettype none
`include "status_led_regs.svh"
module status_led
  import status_led_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = `SLOT_CYCLES
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  vbus_present,
  input  wire logic                  host_suspend,
  input  wire logic                  suspend_low_power,
  input  wire logic                  suspend_sel_wr,
  input  wire logic                  dev_attached,
  input  wire logic                  dev_addressed,
  input  wire logic                  dev_configured,
  input  wire logic                  overcurrent,
  input  wire logic                  general_error,
  input  wire logic                  acq_busy,
  input  wire logic [`DIO_WIDTH-1:0] dio_next,
  output logic                       led,
  output logic                       circuit_enable,
  output logic                       acq_abort,
  output logic                       result_discard,
  output logic                       low_power,
  output logic [`DIO_WIDTH-1:0]      dio_out
);
  import status_led_pkg::*;

  // ************************************************
  // Input synchronisers
  // ************************************************
  // Pins arrive asynchronously: three stages, accept when 2nd and 3rd agree
  logic [2:0] s_vbus, s_susp, s_oc;
  logic       vbus_ok, susp_ok, oc_ok;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_vbus <= 3'h0;
      s_susp <= 3'h0;
      s_oc   <= 3'h0;
    end else begin
      s_vbus <= {s_vbus[1:0], vbus_present};
      s_susp <= {s_susp[1:0], host_suspend};
      s_oc   <= {s_oc[1:0], overcurrent};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vbus_ok <= 1'b0;
      susp_ok <= 1'b0;
      oc_ok   <= 1'b0;
    end else begin
      if (s_vbus[1] == s_vbus[2]) vbus_ok <= s_vbus[2];
      if (s_susp[1] == s_susp[2]) susp_ok <= s_susp[2];
      if (s_oc[1] == s_oc[2])     oc_ok   <= s_oc[2];
    end
  end

  // ************************************************
  // Power and suspend control
  // ************************************************
  logic sel_low_power;
  logic oc_trip;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sel_low_power <= `HOLD_LOW_DEFAULT;
    end else if (suspend_sel_wr) begin
      sel_low_power <= suspend_low_power;
    end
  end

  // Trip latches until power goes away; no auto-retry into the same fault
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !vbus_ok) begin
      oc_trip <= 1'b0;
    end else if (oc_ok) begin
      oc_trip <= 1'b1;
    end
  end

  wire powered     = vbus_ok && !oc_trip;
  wire in_low      = susp_ok && sel_low_power;
  wire in_static   = susp_ok && !sel_low_power;
  wire next_enable = powered && !in_low;
  wire next_abort  = acq_busy && !next_enable;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      circuit_enable <= 1'b0;
      low_power      <= 1'b0;
      acq_abort      <= 1'b0;
      result_discard <= 1'b0;
    end else begin
      circuit_enable <= next_enable;
      low_power      <= in_low;
      acq_abort      <= next_abort;
      result_discard <= next_abort;
    end
  end

  // Outputs freeze while statically suspended; zero when unpowered
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !next_enable) begin
      dio_out <= '0;
    end else if (!in_static) begin
      dio_out <= dio_next;
    end
  end

  // ************************************************
  // Pattern selection
  // ************************************************
  wire       supply_fault = oc_trip;
  wire [2:0] want_count   =
      supply_fault   ? 3'h3 :
      general_error  ? 3'h4 :
      dev_configured ? 3'h0 :
      dev_addressed  ? 3'h2 :
      dev_attached   ? 3'h1 : 3'h0;
  wire       want_on      = !supply_fault && !general_error && dev_configured;
  wire       dark         = !vbus_ok || in_low;

  // ************************************************
  // Flash sequencer
  // ************************************************
  seq_state_t state, next_state;
  logic [2:0] flashes;
  logic [2:0] slot;
  logic       lit;
  logic       slot_tick, half_tick;
  wire        restart = (state == seq_idle);

  slot_timer #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_slot (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .restart   (restart),
    .slot_tick (slot_tick),
    .half_tick (half_tick)
  );

  always_comb begin
    next_state = state;
    case (state)
      // Patterns open with the dark gap so a steady-on LED never runs
      // straight into a flash
      seq_idle:  next_state = (want_count != 3'h0) ? seq_gap : seq_idle;
      seq_flash: if (slot_tick && slot == flashes - 3'h1) begin
        next_state = seq_gap;
      end
      seq_gap:   if (slot_tick && slot == 3'(`GAP_SLOTS - 1)) begin
        next_state = (want_count != 3'h0) ? seq_flash : seq_idle;
      end
      default:   next_state = seq_idle;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || dark) begin
      state   <= seq_idle;
      flashes <= 3'h0;
      slot    <= 3'h0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        slot <= 3'h0;
      end else if (slot_tick) begin
        slot <= slot + 3'h1;
      end
      // Count latched only at a cycle start
      if (next_state == seq_flash && state != seq_flash) begin
        flashes <= want_count;
      end
    end
  end

  // Lit for the first half of each one-second flash slot
  always_ff @(posedge clk_sys) begin
    if (!rst_n || next_state != seq_flash) begin
      lit <= 1'b0;
    end else if (state != seq_flash || slot_tick) begin
      lit <= 1'b1;
    end else if (half_tick) begin
      lit <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || dark) begin
      led <= 1'b0;
    end else if (state == seq_idle) begin
      led <= want_on;
    end else begin
      // Look ahead so the closing slot tick does not add a stray pulse
      led <= (next_state == seq_flash) && (lit || slot_tick);
    end
  end

endmodule
`default_nettype wire

/* File: tb/status_led_asserts.sv */
// Checker for the status LED block
`timescale 1ns/100ps
`default_nettype none
`include "status_led_regs.svh"
module status_led_asserts #(
  parameter int unsigned SLOT_CYCLES = 20
) (
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  vbus_present,
  input wire logic                  host_suspend,
  input wire logic                  overcurrent,
  input wire logic                  acq_busy,
  input wire logic                  led,
  input wire logic                  circuit_enable,
  input wire logic                  acq_abort,
  input wire logic                  result_discard,
  input wire logic                  low_power,
  input wire logic [`DIO_WIDTH-1:0] dio_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ********************************
  // Pin causes: 6 or 7 samples span sync
  // ********************************
  reset_clear_a: assert property (
    disable iff (1'b0) !rst_n |=> !led && !circuit_enable && dio_out == '0)
    else $error("outputs not cleared by reset");
  unpowered_dark_a: assert property (
    !vbus_present [*7] |-> !led && !circuit_enable && dio_out == '0)
    else $error("led or circuitry active without bus power");
  overcurrent_off_a: assert property (
    overcurrent [*7] |-> !circuit_enable)
    else $error("circuitry left on under overcurrent");
  abort_pair_a: assert property (
    acq_abort |-> result_discard && $past(acq_busy))
    else $error("abort without discard or without acquisition");
  static_freeze_a: assert property (
    (vbus_present && host_suspend && !overcurrent && !low_power) [*7]
    |=> $stable(dio_out))
    else $error("digital outputs moved in static suspend");
  lowpower_dark_a: assert property (
    low_power |-> !led)
    else $error("led lit in low power");
  suspend_exit_a: assert property (
    !host_suspend [*6] |-> !low_power)
    else $error("low power held without suspend");
  flash_width_a: assert property (
    $rose(led) |=> (led || !vbus_present || host_suspend) [*8])
    else $error("flash shorter than half a slot");
  dark_width_a: assert property (
    $fell(led) |=> (!led) [*8])
    else $error("dark spell shorter than half a slot");
endmodule
`default_nettype wire

/* File: tb/usb_host_model.sv */
// Behavioural host: bus power, suspend and enumeration progress
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
  input  wire logic       pwr_on,
  input  wire logic       sus,
  input  wire logic [1:0] enum_lvl,
  output logic            vbus_present,
  output logic            host_suspend,
  output logic            dev_attached,
  output logic            dev_addressed,
  output logic            dev_configured
);
  // Unpowered host cannot enumerate or suspend anything
  assign vbus_present   = pwr_on;
  assign host_suspend   = pwr_on & sus;
  assign dev_attached   = pwr_on & (enum_lvl != 2'h0);
  assign dev_addressed  = pwr_on & (enum_lvl >= 2'h2);
  assign dev_configured = pwr_on & (enum_lvl == 2'h3);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Testbench for the status LED block
`timescale 1ns/100ps
`default_nettype none
`include "status_led_regs.svh"
module tb;
  localparam int unsigned SC = 20;
  logic       clk_sys = 1'b0, rst_n = 1'b0, pwr_on = 1'b0, sus = 1'b0;
  logic       sus_lp = 1'b0, sel_wr = 1'b0, ovc = 1'b0, gerr = 1'b0;
  logic       busy = 1'b0, led, cen, abrt, disc, lowp;
  logic [1:0] enum_lvl = 2'h0;
  logic [7:0] dio_next = 8'h00, dio_out;
  wire        vbus, hsus, att, adr, cfg;
  int         bad_count = 0, n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  usb_host_model u_host (.pwr_on(pwr_on), .sus(sus), .enum_lvl(enum_lvl),
    .vbus_present(vbus), .host_suspend(hsus), .dev_attached(att),
    .dev_addressed(adr), .dev_configured(cfg));
  status_led #(.SLOT_CYCLES(SC)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .vbus_present(vbus), .host_suspend(hsus), .suspend_low_power(sus_lp),
    .suspend_sel_wr(sel_wr), .dev_attached(att), .dev_addressed(adr),
    .dev_configured(cfg), .overcurrent(ovc), .general_error(gerr),
    .acq_busy(busy), .dio_next(dio_next), .led(led), .circuit_enable(cen),
    .acq_abort(abrt), .result_discard(disc), .low_power(lowp),
    .dio_out(dio_out));
  // ****************
  // Shared helpers
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Old pattern may finish first, so settle before counting
  task automatic blinks(input logic [7:0] n);
    int k;
    logic [7:0] c;
    logic p;
    c = 8'h00;
    p = 1'b0;
    k = 0;
    wt(200);
    while (led !== 1'b0 && k < 300) begin k++; wt(1); end
    while (led !== 1'b1 && k < 600) begin k++; wt(1); end
    repeat ((n + 3) * SC) begin
      if (led === 1'b1 && p !== 1'b1) c++;
      p = led;
      wt(1);
    end
    chk(c, n);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic sc_enum();
    pwr_on = 1'b1;
    enum_lvl = 2'h1;
    blinks(8'h01);
    enum_lvl = 2'h2;
    blinks(8'h02);
    enum_lvl = 2'h3;
    wt(200);
    repeat (4) begin chk(led, 1'b1); wt(37); end
    gerr = 1'b1;
    blinks(8'h04);
    gerr = 1'b0;
  endtask
  task automatic sc_fault();
    ovc = 1'b1;
    blinks(8'h03);
    chk(cen, 1'b0);
    ovc = 1'b0;
    busy = 1'b1;
    pwr_on = 1'b0;
    wt(10);
    chk({abrt, disc}, 8'h03);
    chk({cen, led}, 8'h00);
    busy = 1'b0;
    pwr_on = 1'b1;
  endtask
  task automatic sc_suspend();
    wt(200);
    dio_next = 8'h5a;
    wt(3);
    sus = 1'b1;
    wt(10);
    dio_next = 8'ha5;
    wt(5);
    chk(dio_out, 8'h5a);
    chk(lowp, 1'b0);
    sus = 1'b0;
    wt(10);
    chk(dio_out, 8'ha5);
    sus_lp = 1'b1;
    sel_wr = 1'b1;
    wt(1);
    sel_wr = 1'b0;
    sus = 1'b1;
    wt(10);
    chk({lowp, led}, 8'h02);
    sus = 1'b0;
  endtask
  initial begin
    wt(3);
    rst_n = 1'b1;
    sc_enum();
    sc_fault();
    sc_suspend();
    conclude();
  end
  initial begin
    #300000;
    bad_count++;
    conclude();
  end
endmodule
bind status_led status_led_asserts #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (
  .clk_sys, .rst_n, .vbus_present, .host_suspend, .overcurrent, .acq_busy,
  .led, .circuit_enable, .acq_abort, .result_discard, .low_power, .dio_out);
`default_nettype wire
